// ---- sls_led_stream.sv ----
// Contract
// - Serial mode fixed by straps at reset
// - No global interrupt while serial mode active
// - Standard mode: serial strap high, low-cost low
// - Active-low stream, 48 bits per frame
// - Data changes on shift clock falling edge
// - 3.125 MHz forced fast, else 2.5 MHz
// - Frame pulse once per 48 bits
// - Frame pulse with port one bit zero
// - Ports one to eight, bits zero to five
// - Two select bits choose bit content
// - Select 00: rx tx link speed col fdx
// - Select 01: activity, port int, global int
// - Select 1x: activity, fdx, col or global
// - Global interrupt is OR of port interrupts
`include "sls_params.svh"
`timescale 1ns/1ps
`default_nettype none

module sls_led_stream (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic link_clk,
  input wire logic serial_led_strap,
  input wire logic low_cost_led_strap,
  input wire logic forced_fast,
  input wire logic [7:0] port_receive,
  input wire logic [7:0] port_transmit,
  input wire logic [7:0] port_link,
  input wire logic [7:0] speed_fast_ind,
  input wire logic [7:0] collision_ind,
  input wire logic [7:0] full_duplex_ind,
  input wire logic [7:0] port_activity,
  input wire logic [7:0] port_interrupt,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic led_serial_out,
  output logic led_shift_clock,
  output logic led_frame_pulse,
  output logic global_int_n
);

  // ****************************************************************
  // Link-side capture of port status
  // ****************************************************************
  logic [63:0] link_status;
  logic [63:0] status_sync;

  always_ff @(posedge link_clk) begin
    link_status <= {port_interrupt, port_activity, full_duplex_ind,
                    collision_ind, speed_fast_ind, port_link,
                    port_transmit, port_receive};
  end

  sls_sync #(
    .WIDTH(64)
  ) u_status_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in(link_status),
    .sync_out(status_sync)
  );

  logic [7:0] st_rx;
  logic [7:0] st_tx;
  logic [7:0] st_link;
  logic [7:0] st_speed;
  logic [7:0] st_col;
  logic [7:0] st_fdx;
  logic [7:0] st_act;
  logic [7:0] st_pint;
  logic st_gint;

  assign st_rx = status_sync[7:0];
  assign st_tx = status_sync[15:8];
  assign st_link = status_sync[23:16];
  assign st_speed = status_sync[31:24];
  assign st_col = status_sync[39:32];
  assign st_fdx = status_sync[47:40];
  assign st_act = status_sync[55:48];
  assign st_pint = status_sync[63:56];
  assign st_gint = |st_pint;

  // ****************************************************************
  // Strap capture
  // ****************************************************************
  logic [1:0] strap_sync;
  logic [1:0] strap_wait;
  logic mode_serial;
  logic strap_lowcost;
  logic any_serial;
  sls_pkg::sls_state_e state;

  sls_sync #(
    .WIDTH(2)
  ) u_strap_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in({low_cost_led_strap, serial_led_strap}),
    .sync_out(strap_sync)
  );

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      strap_wait <= 2'h0;
    end else if (strap_wait != `SLS_STRAP_WAIT) begin
      strap_wait <= strap_wait + 2'h1;
    end
  end

  // Straps latched once after release, never again
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mode_serial <= 1'b0;
      strap_lowcost <= 1'b0;
      any_serial <= 1'b0;
    end else if (state == sls_pkg::SLS_ST_STRAP &&
                 strap_wait == `SLS_STRAP_WAIT) begin
      mode_serial <= strap_sync[0] & ~strap_sync[1];
      strap_lowcost <= strap_sync[1];
      // Either serial mode needs the serial strap high
      any_serial <= strap_sync[0];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= sls_pkg::SLS_ST_STRAP;
    end else begin
      case (state)
        sls_pkg::SLS_ST_STRAP: begin
          if (strap_wait == `SLS_STRAP_WAIT) begin
            if (strap_sync[0] & ~strap_sync[1]) begin
              state <= sls_pkg::SLS_ST_RUN;
            end else begin
              state <= sls_pkg::SLS_ST_OFF;
            end
          end
        end
        sls_pkg::SLS_ST_OFF: begin
          state <= sls_pkg::SLS_ST_OFF;
        end
        sls_pkg::SLS_ST_RUN: begin
          state <= sls_pkg::SLS_ST_RUN;
        end
        default: begin
          state <= sls_pkg::SLS_ST_STRAP;
        end
      endcase
    end
  end

  // ****************************************************************
  // Register bus
  // ****************************************************************
  logic [1:0] led_sel;
  logic rate_fast;
  logic access;
  logic hit_sel;
  logic hit_status;
  logic [31:0] status_word;

  assign access = psel & penable;
  assign hit_sel = (paddr == `SLS_ADDR_LED_SEL);
  assign hit_status = (paddr == `SLS_ADDR_STATUS);

  always_comb begin
    status_word = 32'h0;
    status_word[`SLS_ST_MODE_BIT] = mode_serial;
    status_word[`SLS_ST_LOWCOST_BIT] = strap_lowcost;
    status_word[`SLS_ST_FAST_BIT] = rate_fast;
    status_word[`SLS_ST_PINT_LSB +: 8] = st_pint;
    status_word[`SLS_ST_GINT_BIT] = st_gint;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pready <= 1'b0;
    end else begin
      pready <= access & ~pready;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (access & ~pready) begin
      pslverr <= ~(hit_sel | hit_status);
      if (pwrite) begin
        prdata <= 32'h0;
      end else if (hit_sel) begin
        prdata <= {16'h0, led_sel, 14'h0};
      end else if (hit_status) begin
        prdata <= status_word;
      end else begin
        prdata <= 32'h0;
      end
    end else begin
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      led_sel <= `SLS_SEL_RESET;
    end else if (access && pready && pwrite && hit_sel && pstrb[1]) begin
      led_sel <= pwdata[`SLS_SEL_HI_BIT:`SLS_SEL_LO_BIT];
    end
  end

  // ****************************************************************
  // Per-port bit mapping
  // ****************************************************************
  logic [`SLS_FRAME_BITS-1:0] live_bits;

  genvar p;
  generate
    for (p = 0; p < `SLS_PORTS; p++) begin : g_port
      assign live_bits[p*6+0] = (led_sel == 2'h0) ? st_rx[p] : st_act[p];
      assign live_bits[p*6+1] = led_sel[1] ? st_fdx[p] :
                                (led_sel[0] ? st_pint[p] : st_tx[p]);
      assign live_bits[p*6+2] = st_link[p];
      assign live_bits[p*6+3] = st_speed[p];
      assign live_bits[p*6+4] = led_sel[0] ? st_gint : st_col[p];
      assign live_bits[p*6+5] = st_fdx[p];
    end
  endgenerate

  // ****************************************************************
  // Shift clock divider
  // ****************************************************************
  sls_pkg::sls_div_t div_cnt;
  sls_pkg::sls_div_t half_last;
  logic run;
  logic fall;

  assign run = (state == sls_pkg::SLS_ST_RUN);
  assign half_last = rate_fast ? 5'(`SLS_HALF_FAST - 1) :
                     5'(`SLS_HALF_SLOW - 1);
  assign fall = run && (div_cnt == half_last) && led_shift_clock;

  always_ff @(posedge clk) begin
    if (!reset_n || !run) begin
      div_cnt <= 5'h0;
    end else if (div_cnt == half_last) begin
      div_cnt <= 5'h0;
    end else begin
      div_cnt <= div_cnt + 5'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n || !run) begin
      led_shift_clock <= 1'b1;
    end else if (div_cnt == half_last) begin
      led_shift_clock <= ~led_shift_clock;
    end
  end

  // ****************************************************************
  // Serialiser
  // ****************************************************************
  logic [5:0] bit_idx;
  logic [`SLS_FRAME_BITS-1:0] frame_bits;
  logic [`SLS_FRAME_BITS-1:0] next_frame_bits;

  assign next_frame_bits = (bit_idx == 6'h0) ? live_bits : frame_bits;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rate_fast <= 1'b0;
    end else if (fall && bit_idx == 6'h0) begin
      rate_fast <= forced_fast;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bit_idx <= 6'h0;
      frame_bits <= '0;
    end else if (fall) begin
      frame_bits <= next_frame_bits;
      if (bit_idx == `SLS_LAST_BIT) begin
        bit_idx <= 6'h0;
      end else begin
        bit_idx <= bit_idx + 6'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n || !run) begin
      led_serial_out <= 1'b1;
      led_frame_pulse <= 1'b0;
    end else if (fall) begin
      led_serial_out <= ~next_frame_bits[bit_idx];
      led_frame_pulse <= (bit_idx == 6'h0);
    end
  end

  // ****************************************************************
  // Global interrupt output
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      global_int_n <= 1'b1;
    end else if (state != sls_pkg::SLS_ST_OFF || any_serial) begin
      global_int_n <= 1'b1;
    end else begin
      global_int_n <= ~st_gint;
    end
  end

endmodule

`default_nettype wire

// ---- sls_params.svh ----
`ifndef SLS_PARAMS_SVH
`define SLS_PARAMS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define SLS_IDX_LED_SEL 10'h01a
`define SLS_IDX_STATUS 10'h01b
`define SLS_ADDR_LED_SEL 12'({`SLS_IDX_LED_SEL, 2'b00})
`define SLS_ADDR_STATUS 12'({`SLS_IDX_STATUS, 2'b00})

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define SLS_SEL_LO_BIT 14
`define SLS_SEL_HI_BIT 15
`define SLS_SEL_RESET 2'h0
`define SLS_ST_MODE_BIT 0
`define SLS_ST_LOWCOST_BIT 1
`define SLS_ST_FAST_BIT 2
`define SLS_ST_PINT_LSB 8
`define SLS_ST_GINT_BIT 16

// ****************************************************************
// Frame layout
// ****************************************************************
`define SLS_PORTS 8
`define SLS_BITS_PER_PORT 6
`define SLS_FRAME_BITS 48
`define SLS_LAST_BIT 6'h2f

// ****************************************************************
// Timing
// ****************************************************************
`define SLS_CLK_FREQ_KHZ 100000
`define SLS_FAST_FREQ_KHZ 3125
`define SLS_SLOW_FREQ_KHZ 2500
`define SLS_HALF_FAST (`SLS_CLK_FREQ_KHZ / (2 * `SLS_FAST_FREQ_KHZ))
`define SLS_HALF_SLOW (`SLS_CLK_FREQ_KHZ / (2 * `SLS_SLOW_FREQ_KHZ))
`define SLS_STRAP_WAIT 2'h3

`endif

// ---- sls_pkg.sv ----
package sls_pkg;

  typedef enum logic [2:0] {
    SLS_ST_STRAP = 3'b001,
    SLS_ST_OFF = 3'b010,
    SLS_ST_RUN = 3'b100
  } sls_state_e;

  typedef logic [4:0] sls_div_t;

endpackage

// ---- sls_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Two-stage level synchroniser
// ****************************************************************
module sls_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

`default_nettype wire

// ---- sls_led_shifter.sv ----
`timescale 1ns/1ps
`default_nettype none
// ********
// Display shift register
// ********
module sls_led_shifter (
  input wire logic led_shift_clock,
  input wire logic led_serial_out,
  input wire logic led_frame_pulse,
  output logic [47:0] frame_bits,
  output int frames
);
  logic [47:0] sr;
  int idx = -1;
  initial frames = 0;
  always @(posedge led_shift_clock) begin
    if (led_frame_pulse) idx = 0;
    if (idx >= 0) begin
      sr[idx] = led_serial_out;
      if (idx == 47) begin
        frame_bits = sr;
        frames = frames + 1;
        idx = -1;
      end else begin
        idx = idx + 1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- sls_led_stream_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
// ********
// Port checker
// ********
module sls_led_stream_sva (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic led_serial_out,
  input wire logic led_shift_clock,
  input wire logic led_frame_pulse,
  input wire logic global_int_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [5:0] gap;
  logic gap_ok;
  logic [6:0] falls;
  logic fr_ok;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      gap <= 6'h0;
      gap_ok <= 1'b0;
    end else if ($changed(led_shift_clock)) begin
      gap <= 6'h0;
      gap_ok <= 1'b1;
    end else begin
      gap <= gap + 6'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      falls <= 7'h0;
      fr_ok <= 1'b0;
    end else if ($rose(led_frame_pulse)) begin
      falls <= 7'h1;
      fr_ok <= 1'b1;
    end else if ($fell(led_shift_clock)) begin
      falls <= falls + 7'h1;
    end
  end
  sequence s_fast_bit;
    ##32 $fell(led_frame_pulse);
  endsequence
  sequence s_slow_bit;
    ##40 $fell(led_frame_pulse);
  endsequence
  a_no_gint_serial: assert property (
    $fell(led_shift_clock) |-> global_int_n) else $error("gint in serial");
  a_data_on_fall: assert property (
    $changed(led_serial_out) |-> $fell(led_shift_clock))
    else $error("data moved off fall");
  a_half_period: assert property (
    $changed(led_shift_clock) && gap_ok |-> gap == 6'h0f || gap == 6'h13)
    else $error("bad half period");
  a_frame_spacing: assert property (
    $rose(led_frame_pulse) && fr_ok |-> falls == 7'h30)
    else $error("frame spacing");
  a_frame_on_fall: assert property (
    $changed(led_frame_pulse) |-> $fell(led_shift_clock))
    else $error("frame off fall");
  a_frame_width: assert property (
    $rose(led_frame_pulse) |-> s_fast_bit or s_slow_bit)
    else $error("frame width");
  a_idle_when_off: assert property (
    !global_int_n |-> led_shift_clock && led_serial_out && !led_frame_pulse)
    else $error("stream active");
  a_ready_follows: assert property (
    psel && penable && !pready |=> pready) else $error("late ready");
  a_ready_pulse: assert property (
    pready |=> !pready) else $error("ready held");
  a_err_with_ready: assert property (
    pslverr |-> pready) else $error("stray error");
endmodule
bind sls_led_stream sls_led_stream_sva u_sva (
  .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .led_serial_out(led_serial_out),
  .led_shift_clock(led_shift_clock), .led_frame_pulse(led_frame_pulse),
  .global_int_n(global_int_n));
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
// ********
// Testbench
// ********
module testbench;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic reset_n = 1'b0;
  logic serial_led_strap = 1'b1;
  logic low_cost_led_strap = 1'b0;
  logic forced_fast = 1'b0;
  logic [7:0] port_receive = 8'h35;
  logic [7:0] port_transmit = 8'hca;
  logic [7:0] port_link = 8'h96;
  logic [7:0] speed_fast_ind = 8'h5a;
  logic [7:0] collision_ind = 8'h0f;
  logic [7:0] full_duplex_ind = 8'h3c;
  logic [7:0] port_activity = 8'hc3;
  logic [7:0] port_interrupt = 8'h21;
  logic [11:0] paddr = 12'h0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic led_serial_out;
  logic led_shift_clock;
  logic led_frame_pulse;
  logic global_int_n;
  logic [47:0] frame_bits;
  int frames;
  int err_total = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic er;
  sls_led_stream uut (.*);
  sls_led_shifter u_sh (.*);
  initial forever #5 clk = ~clk;
  initial begin
    #17;
    forever #62.5 link_clk = ~link_clk;
  end
  task automatic conclude();
    $display("errors %0d compares %0d", err_total, n_compared);
    if (err_total == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      err_total++;
      conclude();
    end
  end
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rst(input logic s, input logic l);
    @(posedge clk);
    reset_n <= 1'b0;
    serial_led_strap <= s;
    low_cost_led_strap <= l;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  task automatic wait_frames(input int n);
    int t;
    t = frames + n;
    while (frames < t) @(posedge clk);
  endtask
  function automatic logic [47:0] exp_frame(input logic [1:0] sel);
    logic [47:0] f;
    for (int p = 0; p < 8; p++) begin
      f[p*6] = sel == 2'h0 ? port_receive[p] : port_activity[p];
      f[p*6+1] = sel == 2'h0 ? port_transmit[p] :
                 sel == 2'h1 ? port_interrupt[p] : full_duplex_ind[p];
      f[p*6+2] = port_link[p];
      f[p*6+3] = speed_fast_ind[p];
      f[p*6+4] = sel[0] ? |port_interrupt : collision_ind[p];
      f[p*6+5] = full_duplex_ind[p];
    end
    return ~f;
  endfunction
  initial begin
    rst(1'b1, 1'b0);
    apb(1'b0, 12'h06c, 32'h0, 4'hf);
    chk(rd[1:0], 2'b01);
    serial_led_strap <= 1'b0;
    for (int s = 0; s < 4; s++) begin
      forced_fast <= s[1];
      apb(1'b1, 12'h068, 32'(s) << 14, 4'hf);
      apb(1'b0, 12'h068, 32'h0, 4'hf);
      chk(rd, 32'(s) << 14);
      wait_frames(2);
      chk(frame_bits, exp_frame(2'(s)));
    end
    apb(1'b1, 12'h068, 32'h0, 4'b1101);
    apb(1'b0, 12'h068, 32'h0, 4'hf);
    chk(rd, 32'h0000c000);
    apb(1'b0, 12'h100, 32'h0, 4'hf);
    chk({er, rd}, {1'b1, 32'h0});
    apb(1'b1, 12'h06c, 32'h0, 4'hf);
    apb(1'b0, 12'h06c, 32'h0, 4'hf);
    chk(rd[0], 1'b1);
    chk(global_int_n, 1'b1);
    rst(1'b0, 1'b0);
    repeat (60) @(posedge clk);
    chk(global_int_n, ~|port_interrupt);
    chk(led_shift_clock, 1'b1);
    @(posedge link_clk);
    port_interrupt <= 8'h00;
    repeat (60) @(posedge clk);
    chk(global_int_n, 1'b1);
    @(posedge link_clk);
    port_interrupt <= 8'h21;
    rst(1'b1, 1'b1);
    repeat (60) @(posedge clk);
    apb(1'b0, 12'h06c, 32'h0, 4'hf);
    chk(rd[1:0], 2'b10);
    chk(global_int_n, 1'b1);
    conclude();
  end
endmodule
`default_nettype wire
